// file: dv/pfs_host_model.sv
`timescale 1ns/1ps
// ----------
// host reading status commands
// ----------
module pfs_host_model
    import pfs_pkg::*;
(
    // clock
    input wire logic clk,
    // command
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    // answer
    input wire pfs_resp_s resp
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
    end
    task automatic xfer(input logic w, input logic [7:0] c,
                        output pfs_resp_s r);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_code = c;
        @(negedge clk);
        cmd_valid = 1'b0;
        // released lines flip so a stale value is never trusted
        cmd_write = ~w;
        cmd_code = ~c;
        r = resp;
    endtask : xfer
endmodule : pfs_host_model

// file: dv/pfs_status_bank_assertions.sv
`timescale 1ns/1ps
// ----------
// status bank checks
// ----------
module pfs_status_bank_assertions
    import pfs_pkg::*;
#(
    parameter int NUM_PAGES = PFS_NUM_PAGES
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // conditions
    input wire pfs_volt_s volt_cond,
    input wire pfs_curr_s curr_cond,
    input wire pfs_temp_s temp_cond,
    input wire pfs_comm_s comm_event,
    input wire logic log_full,
    input wire logic [NUM_PAGES-1:0] page_power_bad,
    input wire logic [NUM_PAGES-1:0] page_seq_off,
    input wire logic [NUM_PAGES-1:0] page_margin_fault,
    input wire logic [7:0] vendor_global_status,
    input wire logic clear_faults,
    // command port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire pfs_resp_s resp,
    input wire logic alert
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic rd_ok;
    logic rd_sum;
    logic rd_cur;
    logic rd_log;
    logic any_seq;
    logic any_bad;
    logic cause;
    assign rd_ok = cmd_valid && !cmd_write;
    assign rd_sum = rd_ok && cmd_code == PFS_CMD_SUMMARY;
    assign rd_cur = rd_ok && cmd_code == PFS_CMD_CURR;
    assign rd_log = rd_ok && cmd_code == PFS_CMD_COMM;
    assign any_seq = |page_seq_off;
    assign any_bad = |page_power_bad;
    // page flags and flash bits are left out on purpose
    assign cause = |{volt_cond, curr_cond, temp_cond, cmd_valid,
                     comm_event.bad_command_bit, comm_event.bad_data_bit};
    sequence s_ov_sum;
        volt_cond.overvoltage_fault_bit ##1 rd_sum;
    endsequence
    sequence s_oc_rd;
        curr_cond.overcurrent_fault_bit ##1 !clear_faults ##1 rd_cur;
    endsequence
    property p_answer;
        cmd_valid |=> resp.valid;
    endproperty
    property p_two_byte;
        rd_sum |=> resp.two_byte && !resp.reject;
    endproperty
    property p_zero;
        resp.two_byte |-> (resp.word & 16'h2689) == 16'h0000;
    endproperty
    property p_seq;
        rd_sum |=> resp.word[6] == $past(any_seq);
    endproperty
    property p_pbad;
        rd_sum |=> resp.word[11] == $past(any_bad);
    endproperty
    property p_ov;
        s_ov_sum |=> resp.word[15] && resp.word[5];
    endproperty
    property p_oc;
        s_oc_rd |=> resp.word[7];
    endproperty
    property p_log;
        rd_log |=> resp.word[0] == $past(log_full) &&
            resp.word[15:8] == 8'h00;
    endproperty
    property p_write;
        cmd_valid && cmd_write |=> resp.reject && resp.word == 16'h0000;
    endproperty
    property p_alert;
        $rose(alert) |-> $past(cause);
    endproperty
    a_answer: assert property (p_answer)
        else $error("no answer");
    a_two_byte: assert property (p_two_byte)
        else $error("summary not two bytes");
    a_zero: assert property (p_zero)
        else $error("reserved summary bit set");
    a_seq: assert property (p_seq)
        else $error("seq off summary wrong");
    a_pbad: assert property (p_pbad)
        else $error("power bad summary wrong");
    a_ov: assert property (p_ov)
        else $error("overvoltage summary missing");
    a_oc: assert property (p_oc)
        else $error("overcurrent bit missing");
    a_log: assert property (p_log)
        else $error("log full bit wrong");
    a_write: assert property (p_write)
        else $error("write not refused");
    a_alert: assert property (p_alert)
        else $error("alert without cause");
endmodule : pfs_status_bank_assertions

// file: dv/pfs_status_bank_tb.sv
`timescale 1ns/1ps
module pfs_status_bank_tb
    import pfs_pkg::*;
;
    localparam int NP = 12;
    // index: spare, main, data, cmd, otw, otf, ocw, ocf, tmo, uvf..ovf
    localparam logic [7:0] CODE [13] = '{8'h7e, 8'h7e, 8'h7e, 8'h7e,
        8'h7d, 8'h7d, 8'h7b, 8'h7b, 8'h7a, 8'h7a, 8'h7a, 8'h7a, 8'h7a};
    localparam int BITP [13] = '{2, 1, 6, 7, 6, 7, 5, 7, 2, 4, 5, 6, 7};
    localparam logic [15:0] SUMM [13] = '{16'h0002, 16'h0002, 16'h0002,
        16'h0002, 16'h0004, 16'h0004, 16'h4000, 16'h4010, 16'h8000,
        16'h8000, 16'h8000, 16'h8000, 16'h8020};
    localparam logic [15:0] PGSUM [4] = '{16'h0040, 16'h0800, 16'h0100,
        16'h1000};
    localparam logic [12:0] ALRT = 13'h1ffc;
    localparam logic [12:0] LVL = 13'h1ef0;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [12:0] src = '0;
    logic [3:0] pg = '0;
    logic [NP-1:0] oh = '0;
    logic log_full = 1'b0;
    logic clear_faults = 1'b0;
    logic cmd_valid;
    logic cmd_write;
    logic [7:0] cmd_code;
    pfs_resp_s resp;
    logic alert;
    int bad_count = 0;
    int samples_checked = 0;
    always #2.5 clk = ~clk;
    pfs_status_bank #(.NUM_PAGES(NP)) u_pfs_status_bank (
        .clk(clk), .rst(rst),
        .volt_cond(pfs_volt_s'(src[12:8])),
        .curr_cond(pfs_curr_s'(src[7:6])),
        .temp_cond(pfs_temp_s'(src[5:4])),
        .comm_event(pfs_comm_s'(src[3:0])),
        .log_full(log_full),
        .page_seq_off(pg[0] ? oh : '0),
        .page_power_bad(pg[1] ? oh : '0),
        .page_margin_fault(pg[2] ? oh : '0),
        .vendor_global_status(pg[3] ? 8'h08 : 8'h00),
        .clear_faults(clear_faults), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code),
        .resp(resp), .alert(alert)
    );
    pfs_host_model u_pfs_host_model (
        .clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .resp(resp)
    );
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] c, input logic [15:0] exp);
        pfs_resp_s r;
        u_pfs_host_model.xfer(1'b0, c, r);
        chk({r.valid, r.reject, r.word}, {2'b10, exp});
        chk(18'(r.two_byte), 18'(c == PFS_CMD_SUMMARY));
    endtask : rd
    task automatic clr();
        @(negedge clk);
        clear_faults = 1'b1;
        @(negedge clk);
        clear_faults = 1'b0;
    endtask : clr
    task automatic t_latch(input int i);
        logic [15:0] b;
        b = 16'h0001 << BITP[i];
        @(negedge clk);
        src[i] = 1'b1;
        // held over the summary read so the checker sees cause then read
        rd(PFS_CMD_SUMMARY, SUMM[i]);
        src[i] = 1'b0;
        rd(CODE[i], b);
        chk(18'(alert), 18'(ALRT[i]));
        clr();
        rd(CODE[i], 16'h0000);
        // a held level must survive a clear in the same cycle
        if (LVL[i])
        begin
            src[i] = 1'b1;
            clr();
            src[i] = 1'b0;
            rd(CODE[i], b);
            clr();
        end
    endtask : t_latch
    task automatic t_page(input int k, input int p);
        oh = '0;
        oh[p] = 1'b1;
        pg[k] = 1'b1;
        rd(PFS_CMD_SUMMARY, PGSUM[k]);
        chk(18'(alert), 18'h0);
        pg[k] = 1'b0;
        rd(PFS_CMD_SUMMARY, 16'h0000);
    endtask : t_page
    task automatic t_log();
        log_full = 1'b1;
        rd(PFS_CMD_COMM, 16'h0001);
        rd(PFS_CMD_SUMMARY, 16'h0000);
        log_full = 1'b0;
        rd(PFS_CMD_COMM, 16'h0000);
    endtask : t_log
    task automatic t_refuse();
        pfs_resp_s r;
        u_pfs_host_model.xfer(1'b0, 8'h00, r);
        chk({r.valid, r.reject, r.word}, {2'b11, 16'h0000});
        rd(PFS_CMD_COMM, 16'h0080);
        chk(18'(alert), 18'h1);
        clr();
        src[12] = 1'b1;
        u_pfs_host_model.xfer(1'b1, PFS_CMD_VOLT, r);
        src[12] = 1'b0;
        chk({r.valid, r.reject, r.word}, {2'b11, 16'h0000});
        rd(PFS_CMD_VOLT, 16'h0080);
        rd(PFS_CMD_COMM, 16'h0040);
        clr();
    endtask : t_refuse
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    initial
    begin
        #100000;
        bad_count++;
        $display("mismatch t=%0t run limit", $time);
        finish_test();
    end
    initial
    begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        rd(PFS_CMD_VOLT, 16'h0000);
        rd(PFS_CMD_CURR, 16'h0000);
        rd(PFS_CMD_TEMP, 16'h0000);
        rd(PFS_CMD_COMM, 16'h0000);
        rd(PFS_CMD_SUMMARY, 16'h0000);
        for (int i = 0; i < 13; i++)
            t_latch(i);
        for (int k = 0; k < 4; k++)
        begin
            t_page(k, 0);
            t_page(k, NP - 1);
        end
        t_log();
        t_refuse();
        finish_test();
    end
endmodule : pfs_status_bank_tb
bind pfs_status_bank pfs_status_bank_assertions #(.NUM_PAGES(NUM_PAGES))
    u_pfs_status_bank_assertions (
    .clk(clk), .rst(rst), .volt_cond(volt_cond), .curr_cond(curr_cond),
    .temp_cond(temp_cond), .comm_event(comm_event), .log_full(log_full),
    .page_power_bad(page_power_bad), .page_seq_off(page_seq_off),
    .page_margin_fault(page_margin_fault),
    .vendor_global_status(vendor_global_status),
    .clear_faults(clear_faults), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .resp(resp), .alert(alert)
);

// file: rtl/pfs_pkg.sv
// ----------------------------------------------------------------------
// fault status summary package
// ----------------------------------------------------------------------
package pfs_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int PFS_NUM_PAGES = 12;
    localparam int PFS_WORD_W = 16;
    localparam int PFS_BYTE_W = 8;

    // ------------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] PFS_CMD_SUMMARY = 8'h79;
    localparam logic [7:0] PFS_CMD_VOLT = 8'h7a;
    localparam logic [7:0] PFS_CMD_CURR = 8'h7b;
    localparam logic [7:0] PFS_CMD_TEMP = 8'h7d;
    localparam logic [7:0] PFS_CMD_COMM = 8'h7e;

    // ------------------------------------------------------------------
    // summary word bit positions, all others read zero
    // ------------------------------------------------------------------
    localparam int PFS_BIT_OUTPUT_VOLTAGE_SUMMARY = 15;
    localparam int PFS_BIT_OUTPUT_CURRENT_SUMMARY = 14;
    localparam int PFS_BIT_VENDOR_STATUS_SUMMARY = 12;
    localparam int PFS_BIT_POWER_BAD_SUMMARY = 11;
    localparam int PFS_BIT_MARGIN_SUMMARY = 8;
    localparam int PFS_BIT_SEQUENCED_DOWN_SUMMARY = 6;
    localparam int PFS_BIT_OVERVOLTAGE_FAULT_SUMMARY = 5;
    localparam int PFS_BIT_OVERCURRENT_FAULT_SUMMARY = 4;
    localparam int PFS_BIT_TEMPERATURE_SUMMARY = 2;
    localparam int PFS_BIT_COMM_MEMORY_LOGIC_SUMMARY = 1;

    // ------------------------------------------------------------------
    // byte register bit positions
    // ------------------------------------------------------------------
    localparam int PFS_VB_OV_FAULT = 7;
    localparam int PFS_VB_OV_WARN = 6;
    localparam int PFS_VB_UV_WARN = 5;
    localparam int PFS_VB_UV_FAULT = 4;
    localparam int PFS_VB_TIMEOUT = 2;
    localparam int PFS_CB_OC_FAULT = 7;
    localparam int PFS_CB_OC_WARN = 5;
    localparam int PFS_TB_OT_FAULT = 7;
    localparam int PFS_TB_OT_WARN = 6;
    localparam int PFS_LB_BAD_COMMAND = 7;
    localparam int PFS_LB_BAD_DATA = 6;
    localparam int PFS_LB_SPARE_FLASH = 2;
    localparam int PFS_LB_MAIN_FLASH = 1;
    localparam int PFS_LB_LOG_FULL = 0;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] PFS_BYTE_ZERO = 8'h00;
    localparam logic [15:0] PFS_WORD_ZERO = 16'h0000;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic overvoltage_fault_bit;
        logic overvoltage_warning_bit;
        logic undervoltage_warning_bit;
        logic undervoltage_fault_bit;
        logic turn_on_timeout_bit;
    } pfs_volt_s;

    typedef struct packed {
        logic overcurrent_fault_bit;
        logic overcurrent_warning_bit;
    } pfs_curr_s;

    typedef struct packed {
        logic overtemp_fault_bit;
        logic overtemp_warning_bit;
    } pfs_temp_s;

    typedef struct packed {
        logic bad_command_bit;
        logic bad_data_bit;
        logic main_flash_corrupt_bit;
        logic spare_flash_corrupt_bit;
    } pfs_comm_s;

    typedef struct packed {
        logic valid;
        logic reject;
        logic two_byte;
        logic [15:0] word;
    } pfs_resp_s;

endpackage : pfs_pkg

// file: rtl/pfs_status_bank.sv
`timescale 1ns/1ps
// Function
// - summary command returns two-byte fault summary
// - bit15 set on voltage fault/warning or timeout
// - bit14 set on overcurrent fault or warning
// - bit12 set when global vendor status set
// - bit11 is OR of page power-bad flags
// - bit8 set on any margining fault
// - bit6 is OR of page sequenced-off flags
// - bit5 set only on overvoltage fault
// - bit4 set only on overcurrent fault
// - bit2 set on overtemperature fault or warning
// - bit1 set on comm/memory/logic fault
// - summary bits 13,10,9,7,3,0 read zero
// - sequenced-off and power-bad never raise alert
// - voltage byte layout bits 7,6,5,4,2
// - voltage bits latch; timeout re-sets only on event
// - current byte: fault bit7, warning bit5
// - current and temperature bits latch, re-set persisting
// - comm, data, flash fault bits latch on events
// - log-full bit is live, not latched
// - logic byte layout bits 7,6,2,1,0
module pfs_status_bank
    import pfs_pkg::*;
#(
    parameter int NUM_PAGES = PFS_NUM_PAGES
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // live voltage conditions, timeout is a one-cycle event
    input wire pfs_volt_s volt_cond,
    // live current and temperature conditions
    input wire pfs_curr_s curr_cond,
    input wire pfs_temp_s temp_cond,
    // one-cycle communication and memory events
    input wire pfs_comm_s comm_event,
    // live fault log state
    input wire logic log_full,
    // per-page flags kept by the page status logic
    input wire logic [NUM_PAGES-1:0] page_power_bad,
    input wire logic [NUM_PAGES-1:0] page_seq_off,
    input wire logic [NUM_PAGES-1:0] page_margin_fault,
    // global page vendor status byte
    input wire logic [7:0] vendor_global_status,
    // one-cycle clear of all latched bits
    input wire logic clear_faults,
    // command port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    // response
    output pfs_resp_s resp,
    // shared alert, level
    output logic alert
);

    // ------------------------------------------------------------------
    // byte assembly
    // ------------------------------------------------------------------
    function automatic logic [7:0] volt_byte(input pfs_volt_s s);
        logic [7:0] b;
        b = PFS_BYTE_ZERO;
        b[PFS_VB_OV_FAULT] = s.overvoltage_fault_bit;
        b[PFS_VB_OV_WARN] = s.overvoltage_warning_bit;
        b[PFS_VB_UV_WARN] = s.undervoltage_warning_bit;
        b[PFS_VB_UV_FAULT] = s.undervoltage_fault_bit;
        b[PFS_VB_TIMEOUT] = s.turn_on_timeout_bit;
        return b;
    endfunction : volt_byte

    function automatic logic [7:0] curr_byte(input pfs_curr_s s);
        logic [7:0] b;
        b = PFS_BYTE_ZERO;
        b[PFS_CB_OC_FAULT] = s.overcurrent_fault_bit;
        b[PFS_CB_OC_WARN] = s.overcurrent_warning_bit;
        return b;
    endfunction : curr_byte

    function automatic logic [7:0] temp_byte(input pfs_temp_s s);
        logic [7:0] b;
        b = PFS_BYTE_ZERO;
        b[PFS_TB_OT_FAULT] = s.overtemp_fault_bit;
        b[PFS_TB_OT_WARN] = s.overtemp_warning_bit;
        return b;
    endfunction : temp_byte

    function automatic logic [7:0] comm_byte(input pfs_comm_s s,
                                             input logic full);
        logic [7:0] b;
        b = PFS_BYTE_ZERO;
        b[PFS_LB_BAD_COMMAND] = s.bad_command_bit;
        b[PFS_LB_BAD_DATA] = s.bad_data_bit;
        b[PFS_LB_SPARE_FLASH] = s.spare_flash_corrupt_bit;
        b[PFS_LB_MAIN_FLASH] = s.main_flash_corrupt_bit;
        b[PFS_LB_LOG_FULL] = full;
        return b;
    endfunction : comm_byte

    function automatic logic is_status_cmd(input logic [7:0] code);
        return (code == PFS_CMD_SUMMARY) || (code == PFS_CMD_VOLT) ||
               (code == PFS_CMD_CURR) || (code == PFS_CMD_TEMP) ||
               (code == PFS_CMD_COMM);
    endfunction : is_status_cmd

    // ------------------------------------------------------------------
    // command classification
    // ------------------------------------------------------------------
    logic cmd_known;
    logic cmd_read_ok;
    logic cmd_bad_code;
    logic cmd_bad_write;

    always_comb
    begin
        cmd_known = is_status_cmd(cmd_code);
        cmd_read_ok = cmd_valid && !cmd_write && cmd_known;
        cmd_bad_code = cmd_valid && !cmd_known;
        // a write to a status command is refused as bad data
        cmd_bad_write = cmd_valid && cmd_write && cmd_known;
    end

    // ------------------------------------------------------------------
    // latched status bits
    // ------------------------------------------------------------------
    pfs_volt_s volt_q;
    pfs_volt_s volt_new;
    pfs_curr_s curr_q;
    pfs_curr_s curr_new;
    pfs_temp_s temp_q;
    pfs_temp_s temp_new;
    pfs_comm_s comm_set;
    pfs_comm_s comm_q;
    pfs_comm_s comm_new;

    // levels re-set every cycle they persist; the timeout input is
    // an event, so after a clear it comes back only on a new one
    pfs_sticky_latch #(
        .W($bits(pfs_volt_s))
    ) u_volt_latch (
        .clk(clk),
        .rst(rst),
        .set_vec(volt_cond),
        .clear(clear_faults),
        .q(volt_q),
        .newly_set(volt_new)
    );

    pfs_sticky_latch #(
        .W($bits(pfs_curr_s))
    ) u_curr_latch (
        .clk(clk),
        .rst(rst),
        .set_vec(curr_cond),
        .clear(clear_faults),
        .q(curr_q),
        .newly_set(curr_new)
    );

    pfs_sticky_latch #(
        .W($bits(pfs_temp_s))
    ) u_temp_latch (
        .clk(clk),
        .rst(rst),
        .set_vec(temp_cond),
        .clear(clear_faults),
        .q(temp_q),
        .newly_set(temp_new)
    );

    // own command port refusals feed the logic status too
    always_comb
    begin
        comm_set = comm_event;
        comm_set.bad_command_bit = comm_event.bad_command_bit ||
                                   cmd_bad_code;
        comm_set.bad_data_bit = comm_event.bad_data_bit || cmd_bad_write;
    end

    pfs_sticky_latch #(
        .W($bits(pfs_comm_s))
    ) u_comm_latch (
        .clk(clk),
        .rst(rst),
        .set_vec(comm_set),
        .clear(clear_faults),
        .q(comm_q),
        .newly_set(comm_new)
    );

    // ------------------------------------------------------------------
    // register images
    // ------------------------------------------------------------------
    logic [7:0] volt_img;
    logic [7:0] curr_img;
    logic [7:0] temp_img;
    logic [7:0] comm_img;
    logic [15:0] summary_img;

    always_comb
    begin
        volt_img = volt_byte(volt_q);
        curr_img = curr_byte(curr_q);
        temp_img = temp_byte(temp_q);
        // log full is taken live, never latched
        comm_img = comm_byte(comm_q, log_full);
    end

    // ------------------------------------------------------------------
    // summary sources
    // ------------------------------------------------------------------
    logic volt_any;
    logic curr_any;
    logic temp_any;
    logic comm_any;
    logic vendor_any;
    logic power_bad_any;
    logic seq_off_any;
    logic margin_any;

    // page flags arrive already qualified; only their OR is kept here
    always_comb
    begin
        volt_any = |volt_img;
        curr_any = |curr_img;
        temp_any = |temp_img;
        // log full is a state, not a recorded fault
        comm_any = |comm_q;
        vendor_any = |vendor_global_status;
        power_bad_any = |page_power_bad;
        seq_off_any = |page_seq_off;
        margin_any = |page_margin_fault;
    end

    // summary is pure OR logic over the latched and page bits, so it
    // clears by itself once its sources clear
    always_comb
    begin
        summary_img = PFS_WORD_ZERO;
        summary_img[PFS_BIT_OUTPUT_VOLTAGE_SUMMARY] = volt_any;
        summary_img[PFS_BIT_OUTPUT_CURRENT_SUMMARY] = curr_any;
        summary_img[PFS_BIT_VENDOR_STATUS_SUMMARY] =
            vendor_any;
        summary_img[PFS_BIT_POWER_BAD_SUMMARY] =
            power_bad_any;
        summary_img[PFS_BIT_MARGIN_SUMMARY] =
            margin_any;
        summary_img[PFS_BIT_SEQUENCED_DOWN_SUMMARY] =
            seq_off_any;
        summary_img[PFS_BIT_OVERVOLTAGE_FAULT_SUMMARY] =
            volt_q.overvoltage_fault_bit;
        summary_img[PFS_BIT_OVERCURRENT_FAULT_SUMMARY] =
            curr_q.overcurrent_fault_bit;
        summary_img[PFS_BIT_TEMPERATURE_SUMMARY] = temp_any;
        summary_img[PFS_BIT_COMM_MEMORY_LOGIC_SUMMARY] =
            comm_any;
    end

    // ------------------------------------------------------------------
    // response
    // ------------------------------------------------------------------
    pfs_resp_s resp_reg;
    pfs_resp_s resp_next;

    always_comb
    begin
        resp_next.valid = cmd_valid;
        resp_next.reject = cmd_valid && !cmd_read_ok;
        resp_next.two_byte = 1'b0;
        resp_next.word = PFS_WORD_ZERO;
        if (cmd_read_ok)
        begin
            case (cmd_code)
                PFS_CMD_SUMMARY:
                begin
                    resp_next.two_byte = 1'b1;
                    resp_next.word = summary_img;
                end
                PFS_CMD_VOLT:
                begin
                    resp_next.word = {PFS_BYTE_ZERO, volt_img};
                end
                PFS_CMD_CURR:
                begin
                    resp_next.word = {PFS_BYTE_ZERO, curr_img};
                end
                PFS_CMD_TEMP:
                begin
                    resp_next.word = {PFS_BYTE_ZERO, temp_img};
                end
                PFS_CMD_COMM:
                begin
                    resp_next.word = {PFS_BYTE_ZERO, comm_img};
                end
                default:
                begin
                    resp_next.word = PFS_WORD_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            resp_reg <= '0;
        end
        else
        begin
            resp_reg <= resp_next;
        end
    end

    // ------------------------------------------------------------------
    // alert
    // ------------------------------------------------------------------
    logic alert_reg;
    logic alert_next;
    logic alert_cause;
    logic level_new;
    logic event_new;

    // page power-bad and sequenced-off flags are deliberately left out,
    // as are flash corruption bits, which only report
    always_comb
    begin
        level_new = (|volt_new) || (|curr_new) || (|temp_new);
        // only refused commands and refused data count as events here
        event_new = comm_new.bad_command_bit || comm_new.bad_data_bit;
        alert_cause = level_new || event_new;
        // a fresh cause in the clear cycle keeps the alert up
        alert_next = alert_cause || (alert_reg && !clear_faults);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            alert_reg <= 1'b0;
        end
        else
        begin
            alert_reg <= alert_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign resp = resp_reg;
    assign alert = alert_reg;

endmodule : pfs_status_bank

// file: rtl/pfs_sticky_latch.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// vector of sticky flags, set wins over clear
// ----------------------------------------------------------------------
module pfs_sticky_latch
#(
    parameter int W = 1
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic [W-1:0] set_vec,
    input wire logic clear,
    // state
    output logic [W-1:0] q,
    output logic [W-1:0] newly_set
);

    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    // a set arriving with the clear survives it
    always_comb
    begin
        q_next = set_vec | (q_reg & ~{W{clear}});
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q_reg <= '0;
        end
        else
        begin
            q_reg <= q_next;
        end
    end

    assign q = q_reg;
    assign newly_set = set_vec & ~q_reg;

endmodule : pfs_sticky_latch
